// >>> core/pll_clock_and_stop_mode_control.sv
// Clock synthesizer control, clock output gating and stop mode
// Assumes core strobes and events arrive on i_clock, one cycle long
`timescale 1ns/100ps
`include "pll_clock_consts.svh"
module pll_clock_and_stop_mode_control (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_wr_stb,
    input  wire logic        i_rd_stb,
    input  wire logic        i_stop_request,
    input  wire logic        i_watchdog_timeout,
    input  wire logic        i_wake_event,
    output logic [31:0]      o_rd_data,
    output logic             o_external_clock_output,
    output logic             o_pll_running,
    output logic             o_stop_mode,
    output logic [19:0]      o_core_khz,
    output logic [19:0]      o_bus_khz,
    output logic             o_irq
);
    logic [2:0]                 multiplier_factor_r;
    logic [2:0]                 reduced_frequency_divider_r;
    logic                       clock_output_disable_r;
    logic                       stop_clock_output_select_r;
    logic                       wdog_enable_r;
    logic [2:0]                 irq_stat_r;
    logic [2:0]                 irq_stat_nxt;
    logic [2:0]                 irq_en_r;
    logic [2:0]                 irq_set;
    logic [2:0]                 irq_clr;
    pll_clock_pkg::pwr_state_t  state_r;
    pll_clock_pkg::pwr_state_t  state_nxt;
    logic                       ext_clk_r;
    logic                       ext_clk_en;
    logic                       pll_run_r;
    logic [19:0]                core_khz_r;
    logic [19:0]                bus_khz_r;
    logic [31:0]                rd_data_r;
    logic [31:0]                rd_val;
    logic                       irq_r;
    logic                       synth_wr;
    logic                       lowpwr_wr;
    logic                       wake;
    logic                       wdog_ev;
    logic [19:0]                new_vco;
    logic [19:0]                new_core;
    logic [19:0]                new_bus;
    logic                       new_ok;

    assign o_rd_data               = rd_data_r;
    assign o_external_clock_output = ext_clk_r;
    assign o_pll_running           = pll_run_r;
    assign o_stop_mode             = state_r;
    assign o_core_khz              = core_khz_r;
    assign o_bus_khz               = bus_khz_r;
    assign o_irq                   = irq_r;

    assign synth_wr  = i_wr_stb && (i_addr == `PCK_SYNTH_ADDR);
    assign lowpwr_wr = i_wr_stb && (i_addr == `PCK_LOWPWR_ADDR);

    // Rate of the proposed synthesizer setting
    pll_synth_rate u_rate (
        .i_multiplier_factor         (i_wr_data[`PCK_MUL_MSB:`PCK_MUL_LSB]),
        .i_reduced_frequency_divider (i_wr_data[`PCK_DIV_MSB:`PCK_DIV_LSB]),
        .o_vco_khz                   (new_vco),
        .o_core_khz                  (new_core),
        .o_bus_khz                   (new_bus),
        .o_within_limits             (new_ok)
    );

    // out of range settings are refused
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            multiplier_factor_r         <= `PCK_MUL_RST;
            reduced_frequency_divider_r <= `PCK_DIV_RST;
        end else if (synth_wr && new_ok) begin
            multiplier_factor_r <= i_wr_data[`PCK_MUL_MSB:`PCK_MUL_LSB];
            reduced_frequency_divider_r <=
                i_wr_data[`PCK_DIV_MSB:`PCK_DIV_LSB];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            clock_output_disable_r <= 1'b0;
        end else if (synth_wr) begin
            clock_output_disable_r <= i_wr_data[`PCK_OUT_OFF_BIT];
        end
    end

    // reserved low bits are not stored
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            stop_clock_output_select_r <= 1'b0;
            wdog_enable_r              <= 1'b0;
        end else if (lowpwr_wr) begin
            stop_clock_output_select_r <= i_wr_data[`PCK_STOP_SEL_BIT];
            wdog_enable_r              <= i_wr_data[`PCK_WDOG_EN_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            core_khz_r <= pll_clock_pkg::core_khz(`PCK_MUL_RST,
                                                  `PCK_DIV_RST);
            bus_khz_r  <= pll_clock_pkg::core_khz(`PCK_MUL_RST,
                                                  `PCK_DIV_RST) >> 1;
        end else if (synth_wr && new_ok) begin
            core_khz_r <= new_core;
            bus_khz_r  <= new_bus;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pll_run_r <= 1'b0;
        end else begin
            pll_run_r <= 1'b1;
        end
    end

    // enabled watchdog wakes directly, whatever its interrupt enable
    assign wdog_ev = i_watchdog_timeout && wdog_enable_r;
    assign wake    = wdog_ev || i_wake_event;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pll_clock_pkg::RUN_ST: begin
                if (i_stop_request) begin
                    state_nxt = pll_clock_pkg::STOP_ST;
                end
            end
            pll_clock_pkg::STOP_ST: begin
                if (wake) begin
                    state_nxt = pll_clock_pkg::RUN_ST;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_r <= pll_clock_pkg::RUN_ST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // stop select gates the clock output in stop mode only
    // disable bit gates the clock output
    assign ext_clk_en = !clock_output_disable_r
                        && !((state_r == pll_clock_pkg::STOP_ST)
                             && stop_clock_output_select_r);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ext_clk_r <= 1'b0;
        end else if (ext_clk_en) begin
            ext_clk_r <= !ext_clk_r;
        end else begin
            ext_clk_r <= 1'b0;
        end
    end

    // Events, set wins over clear
    always_comb begin
        irq_set = `PCK_EV_ZERO;
        irq_set[`PCK_EV_WDOG]   = wdog_ev;
        irq_set[`PCK_EV_REJECT] = synth_wr && !new_ok;
        irq_set[`PCK_EV_STOP]   = (state_r == pll_clock_pkg::RUN_ST)
                                  && i_stop_request;
        irq_clr = `PCK_EV_ZERO;
        if (i_wr_stb && (i_addr == `PCK_IRQ_CLR_ADDR)) begin
            irq_clr = i_wr_data[`PCK_EV_MSB:0];
        end
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_stat_r <= `PCK_EV_ZERO;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_en_r <= `PCK_EV_ZERO;
        end else if (i_wr_stb && (i_addr == `PCK_IRQ_EN_ADDR)) begin
            irq_en_r <= i_wr_data[`PCK_EV_MSB:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_nxt & irq_en_r);
        end
    end

    // Read mux, unmapped reads give zero
    always_comb begin
        rd_val = 32'h00000000;
        unique case (i_addr)
            `PCK_SYNTH_ADDR: begin
                rd_val[`PCK_MUL_MSB:`PCK_MUL_LSB] = multiplier_factor_r;
                rd_val[`PCK_DIV_MSB:`PCK_DIV_LSB] =
                    reduced_frequency_divider_r;
                rd_val[`PCK_OUT_OFF_BIT] = clock_output_disable_r;
            end
            `PCK_LOWPWR_ADDR: begin
                rd_val[`PCK_STOP_SEL_BIT] = stop_clock_output_select_r;
                rd_val[`PCK_WDOG_EN_BIT]  = wdog_enable_r;
            end
            `PCK_IRQ_STAT_ADDR: rd_val[`PCK_EV_MSB:0] = irq_stat_r;
            `PCK_IRQ_EN_ADDR:   rd_val[`PCK_EV_MSB:0] = irq_en_r;
            `PCK_FREQ_ADDR:     rd_val[`PCK_RATE_MSB:0] = core_khz_r;
            `PCK_STATE_ADDR: begin
                rd_val[`PCK_STATE_STOP_BIT] = state_r;
                rd_val[`PCK_STATE_RUN_BIT]  = pll_run_r;
            end
            default: rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rd_data_r <= 32'h00000000;
        end else if (i_rd_stb) begin
            rd_data_r <= rd_val;
        end else begin
            rd_data_r <= 32'h00000000;
        end
    end

    sequence s_stop_gated;
        (o_stop_mode && stop_clock_output_select_r)[*2];
    endsequence

    sequence s_stop_kept;
        (o_stop_mode && !stop_clock_output_select_r
         && !clock_output_disable_r)[*2];
    endsequence

    sequence s_output_toggles;
        o_external_clock_output ##1 !o_external_clock_output;
    endsequence

    a_pll_keeps_running: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_stop_mode |-> o_pll_running ##1 o_pll_running)
        else $error("synthesizer stopped in stop mode");

    a_stop_gates_output: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        s_stop_gated |-> !o_external_clock_output)
        else $error("clock output not gated in stop mode");

    a_stop_keeps_output: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        s_stop_kept |-> (o_external_clock_output
                         != $past(o_external_clock_output)))
        else $error("clock output not kept in stop mode");

    a_disable_stops_output: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (synth_wr && i_wr_data[`PCK_OUT_OFF_BIT]) |=> ##1
        !o_external_clock_output)
        else $error("clock output runs while disabled");

    a_reset_output_runs: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        ($past(i_sys_rst) && !i_wr_stb && !i_stop_request) |=>
        s_output_toggles)
        else $error("clock output idle after reset");

    a_write_sets_rate: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (synth_wr && new_ok) |=> (o_core_khz == $past(new_core)))
        else $error("core rate does not follow fields");

    a_reset_ratio: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        $past(i_sys_rst) |-> (o_core_khz == `PCK_RST_CORE_KHZ
                              && multiplier_factor_r == `PCK_MUL_RST))
        else $error("reset rate is not 1.5 times reference");

    a_rate_ceilings: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (o_core_khz <= `PCK_CORE_MAX_KHZ)
        && (o_bus_khz <= `PCK_BUS_MAX_KHZ))
        else $error("core or bus rate above ceiling");

    a_reject_keeps_rate: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (synth_wr && !new_ok) |=> $stable(o_core_khz)
        && irq_stat_r[`PCK_EV_REJECT])
        else $error("out of range setting was taken");

    a_wdog_wakes_only: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (wdog_ev && o_stop_mode) |=> !o_stop_mode
        && irq_stat_r[`PCK_EV_WDOG] && o_pll_running)
        else $error("watchdog did not wake by interrupt");

    a_bus_half_core: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        $changed(o_core_khz) |-> (o_bus_khz == (o_core_khz >> 1)))
        else $error("bus rate is not half core rate");

    a_lowpwr_reserved: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_rd_stb && i_addr == `PCK_LOWPWR_ADDR) |=>
        (o_rd_data[2:0] == 3'h0))
        else $error("reserved bits read nonzero");

    a_stop_entry_flag: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (!o_stop_mode && i_stop_request) |=>
        (o_stop_mode && irq_stat_r[`PCK_EV_STOP]))
        else $error("stop request not taken");

    a_stop_keeps_rate: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (!o_stop_mode && i_stop_request && !synth_wr) |=>
        ($stable(o_core_khz) && o_pll_running))
        else $error("stop entry changed the synthesizer");

    a_wdog_never_resets: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        wdog_ev |=> (irq_stat_r[`PCK_EV_WDOG] && o_pll_running))
        else $error("watchdog event lost or reset the block");

    a_irq_level: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_irq == |(irq_stat_r & $past(irq_en_r)))
        else $error("interrupt line does not follow status");
endmodule

// >>> core/pll_clock_consts.svh
// Constants for the clock synthesizer and stop mode control block
// Assumes a 40 MHz reference on i_clock and a plain register port
// Notes on behaviour
// - The synthesizer keeps running in stop mode; only system reset halts it.
// - On stop entry the clock output pin is kept or gated by the stop select.
// - Setting the clock output disable bit turns the clock output pin off.
// - Out of reset the clock output pin toggles with no software action.
// - System rate is reference times 2(multiplier+2) over 2 to the divider.
// - Reset gives core at 1.5 times reference; multiplier code 1 means 6x.
// - Core stays at or below 166 MHz and internal bus at or below 83 MHz.
// - The core watchdog only raises a wakeup interrupt, never a reset.
`ifndef PLL_CLOCK_CONSTS_SVH
`define PLL_CLOCK_CONSTS_SVH

// Reference 40000 kHz, core limit 166000 kHz, bus limit 83000 kHz
`define PCK_REF_KHZ        20'h09C40
`define PCK_CORE_MAX_KHZ   20'h28870
`define PCK_BUS_MAX_KHZ    20'h14438
`define PCK_MUL_OFFSET     20'h00002
`define PCK_MUL_SCALE      20'h00002

// Register offsets
`define PCK_SYNTH_ADDR     8'h00
`define PCK_LOWPWR_ADDR    8'h04
`define PCK_IRQ_STAT_ADDR  8'h08
`define PCK_IRQ_CLR_ADDR   8'h0C
`define PCK_IRQ_EN_ADDR    8'h10
`define PCK_FREQ_ADDR      8'h14
`define PCK_STATE_ADDR     8'h18

// Field positions
`define PCK_MUL_MSB        2
`define PCK_MUL_LSB        0
`define PCK_DIV_MSB        5
`define PCK_DIV_LSB        3
`define PCK_OUT_OFF_BIT    6
`define PCK_STOP_SEL_BIT   3
`define PCK_WDOG_EN_BIT    4
`define PCK_EV_WDOG        0
`define PCK_EV_REJECT      1
`define PCK_EV_STOP        2
`define PCK_EV_MSB         2
`define PCK_RATE_MSB       19
`define PCK_STATE_STOP_BIT 0
`define PCK_STATE_RUN_BIT  1

// Reset values
`define PCK_MUL_RST        3'h1
`define PCK_DIV_RST        3'h2
`define PCK_EV_ZERO        3'h0
`define PCK_RST_CORE_KHZ   20'h0EA60

`endif

// >>> core/pll_clock_pkg.sv
// Types and rate arithmetic for the clock synthesizer block
// Assumes the constants header is on the include path
`include "pll_clock_consts.svh"
package pll_clock_pkg;
    typedef enum logic {
        RUN_ST  = 1'b0,
        STOP_ST = 1'b1
    } pwr_state_t;

    typedef logic [19:0] khz_t;

    // Synthesizer output before the divider
    function automatic khz_t vco_khz(input logic [2:0] mul_code);
        khz_t factor;
        factor = {17'h00000, mul_code} + `PCK_MUL_OFFSET;
        return khz_t'(`PCK_REF_KHZ * `PCK_MUL_SCALE * factor);
    endfunction

    function automatic khz_t core_khz(input logic [2:0] mul_code,
                                      input logic [2:0] div_code);
        return vco_khz(mul_code) >> div_code;
    endfunction
endpackage

// >>> core/pll_synth_rate.sv
// Rate model of the frequency synthesizer for one field setting
// Assumes the fields come from the register port, same clock
`timescale 1ns/100ps
`include "pll_clock_consts.svh"
module pll_synth_rate (
    input  wire logic [2:0]          i_multiplier_factor,
    input  wire logic [2:0]          i_reduced_frequency_divider,
    output logic [19:0]              o_vco_khz,
    output logic [19:0]              o_core_khz,
    output logic [19:0]              o_bus_khz,
    output logic                     o_within_limits
);
    always_comb begin
        o_vco_khz  = pll_clock_pkg::vco_khz(i_multiplier_factor);
        o_core_khz = pll_clock_pkg::core_khz(i_multiplier_factor,
                                             i_reduced_frequency_divider);
    end

    always_comb begin
        o_bus_khz = o_core_khz >> 1;
    end

    always_comb begin
        o_within_limits = (o_vco_khz <= `PCK_CORE_MAX_KHZ)
                          && (o_core_khz <= `PCK_CORE_MAX_KHZ)
                          && (o_bus_khz <= `PCK_BUS_MAX_KHZ);
    end
endmodule

// >>> test/pll_clock_and_stop_mode_control_test.sv
// Self-checking bench for the clock synthesizer and stop mode block
// Assumes the constants header and package are compiled ahead of it
`timescale 1ns/100ps
`include "pll_clock_consts.svh"
module pll_clock_and_stop_mode_control_test;
    localparam int REF_KHZ = 40000;
    logic        i_clock;
    logic        i_sys_rst;
    logic [7:0]  i_addr;
    logic [31:0] i_wr_data;
    logic        i_wr_stb;
    logic        i_rd_stb;
    logic        i_stop_request;
    logic        i_watchdog_timeout;
    logic        i_wake_event;
    logic [31:0] o_rd_data;
    logic        o_external_clock_output;
    logic        o_pll_running;
    logic        o_stop_mode;
    logic [19:0] o_core_khz;
    logic [19:0] o_bus_khz;
    logic        o_irq;
    int          failures;
    int          checks_done;
    logic [31:0] rv;
    logic        tog;
    logic        low;

    pll_clock_and_stop_mode_control u_pll_clock_and_stop_mode_control (
        .i_clock                 (i_clock),
        .i_sys_rst               (i_sys_rst),
        .i_addr                  (i_addr),
        .i_wr_data               (i_wr_data),
        .i_wr_stb                (i_wr_stb),
        .i_rd_stb                (i_rd_stb),
        .i_stop_request          (i_stop_request),
        .i_watchdog_timeout      (i_watchdog_timeout),
        .i_wake_event            (i_wake_event),
        .o_rd_data               (o_rd_data),
        .o_external_clock_output (o_external_clock_output),
        .o_pll_running           (o_pll_running),
        .o_stop_mode             (o_stop_mode),
        .o_core_khz              (o_core_khz),
        .o_bus_khz               (o_bus_khz),
        .o_irq                   (o_irq)
    );

    always #12.5 i_clock = ~i_clock;

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] exp_core(input int m, input int r);
        return 32'((REF_KHZ * 2 * (m + 2)) >> r);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr_stb  <= 1'b1;
        i_addr    <= a;
        i_wr_data <= d;
        @(posedge i_clock);
        i_wr_stb  <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        i_rd_stb <= 1'b1;
        i_addr   <= a;
        @(posedge i_clock);
        i_rd_stb <= 1'b0;
        #1;
        d = o_rd_data;
    endtask

    // Pulse: 0 stop request, 1 watchdog, 2 wake event
    task automatic pulse(input int which);
        @(posedge i_clock);
        if (which == 0) i_stop_request <= 1'b1;
        if (which == 1) i_watchdog_timeout <= 1'b1;
        if (which == 2) i_wake_event <= 1'b1;
        @(posedge i_clock);
        i_stop_request     <= 1'b0;
        i_watchdog_timeout <= 1'b0;
        i_wake_event       <= 1'b0;
        #1;
    endtask

    task automatic watch_clk(output logic t, output logic l);
        logic [3:0] v;
        v = 4'h0;
        repeat (4) begin
            @(posedge i_clock);
            #1;
            v = {v[2:0], o_external_clock_output};
        end
        t = (v === 4'h5) || (v === 4'hA);
        l = (v === 4'h0);
    endtask

    task automatic t_reset_state();
        check("core_in_reset", 32'(o_core_khz), REF_KHZ * 3 / 2);
        check("bus_in_reset", 32'(o_bus_khz), REF_KHZ * 3 / 4);
        check("pll_in_reset", 32'(o_pll_running), 0);
        check("irq_in_reset", 32'(o_irq), 0);
    endtask

    task automatic t_after_reset();
        tick(1);
        check("pll_after_reset", 32'(o_pll_running), 1);
        watch_clk(tog, low);
        check("extclk_default", 32'(tog), 1);
        rd(`PCK_SYNTH_ADDR, rv);
        check("synth_reset", rv, 32'h0000_0011);
        rd(`PCK_LOWPWR_ADDR, rv);
        check("lowpwr_reset", rv, 32'h0000_0000);
        rd(`PCK_STATE_ADDR, rv);
        check("state_reset", rv, 32'h0000_0002);
        rd(8'h20, rv);
        check("unmapped_read", rv, 32'h0000_0000);
    endtask

    task automatic t_rates();
        for (int r = 0; r < 8; r++) begin
            wr(`PCK_SYNTH_ADDR, 32'(r << 3));
            check("core_rate", 32'(o_core_khz), exp_core(0, r));
            check("bus_rate", 32'(o_bus_khz), exp_core(0, r) >> 1);
            check("bus_max", 32'(o_bus_khz <= 20'h14438), 1);
        end
        // Code 1 multiplies by six, beyond the ceiling from 40 MHz
        wr(`PCK_SYNTH_ADDR, 32'h0000_0001);
        check("refused_rate", 32'(o_core_khz), exp_core(0, 7));
        check("core_max", 32'(o_core_khz <= 20'h28870), 1);
        rd(`PCK_SYNTH_ADDR, rv);
        check("refused_fields", rv, 32'h0000_0038);
        rd(`PCK_IRQ_STAT_ADDR, rv);
        check("refused_status", rv & 32'h2, 32'h2);
        rd(`PCK_FREQ_ADDR, rv);
        check("freq_read", rv, exp_core(0, 7));
        wr(`PCK_SYNTH_ADDR, 32'h0000_0010);
    endtask

    task automatic t_disable();
        wr(`PCK_SYNTH_ADDR, 32'h0000_0050);
        tick(2);
        watch_clk(tog, low);
        check("extclk_disabled", 32'(low), 1);
        check("rate_kept", 32'(o_core_khz), exp_core(0, 2));
        wr(`PCK_SYNTH_ADDR, 32'h0000_0010);
        tick(2);
        watch_clk(tog, low);
        check("extclk_reenabled", 32'(tog), 1);
    endtask

    task automatic t_stop();
        wr(`PCK_IRQ_CLR_ADDR, 32'h0000_0007);
        wr(`PCK_LOWPWR_ADDR, 32'h0000_0000);
        pulse(0);
        tick(1);
        check("stop_entered", 32'(o_stop_mode), 1);
        check("pll_in_stop", 32'(o_pll_running), 1);
        watch_clk(tog, low);
        check("extclk_kept", 32'(tog), 1);
        rd(`PCK_IRQ_STAT_ADDR, rv);
        check("stop_status", rv & 32'h4, 32'h4);
        pulse(2);
        tick(1);
        check("stop_left", 32'(o_stop_mode), 0);
        wr(`PCK_LOWPWR_ADDR, 32'h0000_0008);
        pulse(0);
        tick(2);
        watch_clk(tog, low);
        check("extclk_gated", 32'(low), 1);
        rd(`PCK_STATE_ADDR, rv);
        check("state_stop", rv, 32'h0000_0003);
        pulse(2);
        tick(2);
        watch_clk(tog, low);
        check("extclk_after_wake", 32'(tog), 1);
    endtask

    task automatic t_watchdog();
        wr(`PCK_IRQ_CLR_ADDR, 32'h0000_0007);
        wr(`PCK_LOWPWR_ADDR, 32'h0000_0000);
        pulse(0);
        pulse(1);
        tick(1);
        check("wdog_off_ignored", 32'(o_stop_mode), 1);
        rd(`PCK_IRQ_STAT_ADDR, rv);
        check("wdog_off_status", rv & 32'h1, 32'h0);
        wr(`PCK_LOWPWR_ADDR, 32'h0000_0010);
        wr(`PCK_IRQ_EN_ADDR, 32'h0000_0001);
        pulse(1);
        tick(2);
        check("wdog_wakes", 32'(o_stop_mode), 0);
        check("wdog_no_reset", 32'(o_pll_running), 1);
        check("wdog_irq", 32'(o_irq), 1);
        rd(`PCK_SYNTH_ADDR, rv);
        check("regs_survive", rv, 32'h0000_0010);
        wr(`PCK_IRQ_EN_ADDR, 32'h0000_0000);
        tick(1);
        check("irq_masked", 32'(o_irq), 0);
        wr(`PCK_IRQ_EN_ADDR, 32'h0000_0001);
        tick(1);
        check("irq_unmasked", 32'(o_irq), 1);
        wr(`PCK_IRQ_CLR_ADDR, 32'h0000_0001);
        tick(2);
        check("irq_cleared", 32'(o_irq), 0);
        rd(`PCK_IRQ_STAT_ADDR, rv);
        check("status_cleared", rv & 32'h1, 32'h0);
    endtask

    task automatic t_midrun_reset();
        wr(`PCK_SYNTH_ADDR, 32'h0000_0050);
        @(posedge i_clock);
        i_sys_rst <= 1'b1;
        tick(2);
        check("pll_mid_reset", 32'(o_pll_running), 0);
        check("core_mid_reset", 32'(o_core_khz), REF_KHZ * 3 / 2);
        @(posedge i_clock);
        i_sys_rst <= 1'b0;
        tick(1);
        watch_clk(tog, low);
        check("extclk_after_reset", 32'(tog), 1);
        rd(`PCK_SYNTH_ADDR, rv);
        check("synth_after_reset", rv, 32'h0000_0011);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        i_clock            = 1'b0;
        i_sys_rst          = 1'b1;
        i_addr             = 8'h00;
        i_wr_data          = 32'h0000_0000;
        i_wr_stb           = 1'b0;
        i_rd_stb           = 1'b0;
        i_stop_request     = 1'b0;
        i_watchdog_timeout = 1'b0;
        i_wake_event       = 1'b0;
        failures           = 0;
        checks_done        = 0;
        tick(10);
        t_reset_state();
        @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_after_reset();
        t_rates();
        t_disable();
        t_stop();
        t_watchdog();
        t_midrun_reset();
        finish_test();
    end

    // Hang guard
    initial begin
        #2500000;
        failures++;
        finish_test();
    end
endmodule
